// ==== dv/sald_core_checker.sv ====
`timescale 1ns/1ps
module sald_core_checker (
    // watched design ports
    input wire logic                i_ref_clk,
    input wire logic                i_nrst,
    input wire logic                i_scl,
    input wire sald_pkg::sald_ana_t i_ana,
    input wire sald_pkg::sald_dc_t  i_dc,
    input wire logic                o_sda_out,
    input wire logic                o_sda_oe,
    input wire logic                o_stim,
    input wire logic                o_loopback,
    input wire logic                o_gain4,
    input wire logic                o_cur20,
    input wire logic [3:0]          o_lo_req
);
    wire fault = i_ana.uv | i_ana.ov | i_ana.ot;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // long enough to clear the pin filter
    sequence s_fault_held;
        fault [*8] ##1 fault [*8];
    endsequence
    a_sda_out_low: assert property (o_sda_out == 1'h0)
        else $error("sda data not low");
    a_ack_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("sda moved while scl high");
    a_ctrl_on_write: assert property (($changed(o_gain4) || $changed(o_cur20)) |-> i_scl)
        else $error("gain or current moved outside a write");
    a_stim_high_hold: assert property ($rose(o_stim) |-> o_stim [*8])
        else $error("stimulus high too short");
    a_stim_low_hold: assert property ($fell(o_stim) |-> !o_stim [*8])
        else $error("stimulus low too short");
    a_fault_abort: assert property (s_fault_held |-> !o_stim)
        else $error("stimulus runs during fault");
    a_loopback_start: assert property ($changed(o_loopback) |-> $rose(o_stim))
        else $error("loopback moved outside test start");
    a_lo_after_dc: assert property ($rose(|o_lo_req) |-> $past(i_dc.done) || $past(i_dc.done, 2))
        else $error("line output request without dc result");
endmodule

bind sald_core sald_core_checker sald_core_checker_i (.i_ref_clk, .i_nrst, .i_scl, .i_ana,
    .i_dc, .o_sda_out, .o_sda_oe, .o_stim, .o_loopback, .o_gain4, .o_cur20, .o_lo_req);

// ==== dv/sald_core_tb.sv ====
`timescale 1ns/1ps
`include "sald_map.svh"
module sald_core_tb;
    // stimulus period at frequency code 3
    localparam logic [15:0] PER = 16'h0682;
    logic                i_ref_clk = 1'h0;
    logic                i_nrst = 1'h0;
    logic                scl, h_oe, d_oe, d_out, stim, lb, g4, c20;
    logic [2:0]          flt = 3'h0;
    logic [63:0]         sh = '0;
    int                  dly = 10;
    sald_pkg::sald_dc_t  dc = '0;
    logic                lo_done = 1'h0;
    logic [3:0]          lo_req;
    logic [7:0]          bcfg;
    int                  n_errors = 0;
    int                  checked = 0;
    // open drain bus with pull-up
    wire                 sda = !(h_oe || d_oe);
    // load modelled as a plain delay
    wire sald_pkg::sald_ana_t ana = '{flt[2], flt[1], flt[0], sh[dly]};
    always #2 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) sh <= {sh[62:0], stim};
    sald_core sald_core_i (.i_ref_clk, .i_nrst, .i_scl(scl), .i_sda(sda), .o_sda_out(d_out),
        .o_sda_oe(d_oe), .i_ana(ana), .i_mag_code(8'h5A), .o_stim(stim), .o_loopback(lb),
        .o_gain4(g4), .o_cur20(c20), .i_dc(dc), .i_chan_state(8'h55), .i_lo_done(lo_done),
        .i_lo_present(1'h1), .o_lo_req(lo_req), .o_bridge_cfg(bcfg));
    sald_host_model host_i (.i_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        host_i.rd(a, v[15:8]);
        host_i.rd(a + 8'h01, v[7:0]);
    endtask
    task automatic t_regs;
        logic [7:0] v;
        logic [7:0] offs [6] = '{`SALD_REG_BRIDGE, `SALD_REG_EN_GAIN, `SALD_REG_LB_CUR,
            `SALD_REG_FREQ, `SALD_REG_LO_CTRL, 8'h40};
        foreach (offs[k]) begin
            host_i.rd(offs[k], v);
            check("reset value", v, 16'h0000);
        end
        host_i.wr(`SALD_REG_LB_CUR, 8'h84);
        check("cur20", c20, 16'h0001);
        check("loopback idle", lb, 16'h0000);
        host_i.wr(`SALD_REG_EN_GAIN, 8'h80);
        check("gain one bit", g4, 16'h0000);
        host_i.wr(`SALD_REG_EN_GAIN, 8'hA0);
        check("gain4", g4, 16'h0001);
        host_i.wr(`SALD_REG_BRIDGE, 8'h30);
        check("bridge", bcfg, 16'h0030);
        host_i.wr(`SALD_REG_BRIDGE, 8'h00);
        check("bridge single", bcfg, 16'h0000);
    endtask
    task automatic t_ref(output logic [15:0] ref_ph);
        logic       ok;
        logic [7:0] v;
        dly = 10;
        host_i.wr(`SALD_REG_FREQ, 8'h03);
        host_i.wr(`SALD_REG_LB_CUR, 8'h80);
        host_i.wr(`SALD_REG_EN_GAIN, 8'h08);
        check("loopback", lb, 16'h0001);
        host_i.rd(`SALD_REG_CHSTATE, v);
        check("diag state", v[7:6], `SALD_CS_DIAG);
        host_i.poll(6, ok);
        check("ref done", ok, 16'h0001);
        rd16(`SALD_REG_PHASE_HI, ref_ph);
        host_i.wr(`SALD_REG_EN_GAIN, 8'h00);
    endtask
    task automatic t_load(input logic [15:0] ref_ph);
        logic        ok;
        logic [15:0] v;
        dly = 40;
        host_i.wr(`SALD_REG_LB_CUR, 8'h04);
        host_i.wr(`SALD_REG_EN_GAIN, 8'hA4);
        host_i.poll(4, ok);
        check("load done", ok, 16'h0001);
        rd16(`SALD_REG_PHASE_HI, v);
        check("phase delta", v - ref_ph, 16'h001E);
        rd16(`SALD_REG_REFA_HI, v);
        check("ref pair a", v, ref_ph);
        rd16(`SALD_REG_STIM_HI, v);
        check("stim count", v, PER);
        host_i.rd(`SALD_REG_IMP_CH2, v[7:0]);
        check("mag ch2", v[7:0], 16'h005A);
        host_i.wr(`SALD_REG_EN_GAIN, 8'hA0);
    endtask
    task automatic t_abort;
        logic        ok;
        logic [7:0]  v;
        logic [15:0] p0, p1;
        rd16(`SALD_REG_PHASE_HI, p0);
        host_i.wr(`SALD_REG_LO_CTRL, 8'h01);
        host_i.wr(`SALD_REG_EN_GAIN, 8'h02);
        flt = 3'h4;
        tick(40);
        flt = 3'h0;
        host_i.poll(2, ok);
        check("abort hiz", ok, 16'h0001);
        rd16(`SALD_REG_PHASE_HI, p1);
        check("no result", p1, p0);
        host_i.rd(`SALD_REG_LO_STAT, v);
        check("blocked", v[7], 16'h0001);
        host_i.wr(`SALD_REG_EN_GAIN, 8'h00);
        host_i.wr(`SALD_REG_EN_GAIN, 8'h01);
        host_i.rd(`SALD_REG_CHSTATE, v);
        check("refused", v[1:0], `SALD_CS_HIZ);
        host_i.wr(`SALD_REG_EN_GAIN, 8'h00);
        dc = '{4'h8, 1'h1};
        tick(1);
        dc = '0;
        tick(2);
        check("lo request", lo_req, 16'h0008);
        lo_done = 1'h1;
        tick(1);
        lo_done = 1'h0;
        host_i.rd(`SALD_REG_LO_STAT, v);
        check("lo status", v, 16'h0008);
        host_i.wr(`SALD_REG_EN_GAIN, 8'h01);
        host_i.rd(`SALD_REG_CHSTATE, v);
        check("restart", v[1:0], `SALD_CS_DIAG);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        logic [15:0] r;
        tick(6);
        i_nrst = 1'h1;
        tick(10);
        t_regs();
        t_ref(r);
        t_load(r);
        t_abort();
        tally_and_finish();
    end
    initial begin
        tick(99000);
        n_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule

// ==== dv/sald_host_model.sv ====
`timescale 1ns/1ps
`include "sald_map.svh"
module sald_host_model (
    // clock
    input  wire logic i_clk,
    // i2c pins
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    initial begin
        o_scl = 1'h1;
        o_sda_oe = 1'h0;
    end
    task automatic hp(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // high phase kept at 20 clocks for the pin filter
    task automatic bit_io(input logic b, output logic r);
        o_sda_oe = !b;
        hp(10);
        o_scl = 1'h1;
        hp(20);
        r = i_sda;
        o_scl = 1'h0;
        hp(10);
    endtask
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic n);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'h1, n);
    endtask
    task automatic start;
        o_sda_oe = 1'h0;
        hp(10);
        o_scl = 1'h1;
        hp(20);
        o_sda_oe = 1'h1;
        hp(20);
        o_scl = 1'h0;
        hp(10);
    endtask
    task automatic stop;
        o_sda_oe = 1'h1;
        hp(10);
        o_scl = 1'h1;
        hp(20);
        o_sda_oe = 1'h0;
        hp(20);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       n;
        start();
        byte_io({`SALD_I2C_ADDR, 1'h0}, q, n);
        byte_io(a, q, n);
        byte_io(d, q, n);
        stop();
    endtask
    // single byte read, ended by nack
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic n;
        start();
        byte_io({`SALD_I2C_ADDR, 1'h0}, d, n);
        byte_io(a, d, n);
        start();
        byte_io({`SALD_I2C_ADDR, 1'h1}, d, n);
        byte_io(8'hFF, d, n);
        stop();
    endtask
    task automatic poll(input int sh, output logic ok);
        logic [7:0] v;
        ok = 1'h0;
        for (int k = 0; k < 30 && !ok; k++) begin
            rd(`SALD_REG_CHSTATE, v);
            ok = (v[sh+:2] === `SALD_CS_HIZ);
        end
    endtask
endmodule

// ==== rtl/sald_core.sv ====
// Function
// - with line-output enable set, open-load channels get a line-output check
// - ac test drives own stimulus, reports phase and impedance in registers
// - undervoltage, overvoltage or overtemperature aborts a running ac test
// - after an abort, ac tests are refused until a dc diagnostic completes
// - bit 7 of 0x16 selects internal loopback for reference phase
// - reference kept for channels 1 and 3; 2 uses 1, 4 uses 3
// - test frequency from 0x2A; reset value selects 18.75 kHz
// - bits 3..0 of 0x15 start channels 1..4; host clears afterwards
// - phase is 16 bits, high byte 0x1B, low byte 0x1C
// - stimulus period count, high byte 0x1D, low byte 0x1E
// - 0x0F shows channel going from ac diagnostic to high impedance
// - phase result is stored as the channel of a completed test enters high impedance
// - load measurement captures one impedance code per channel, 0x17..0x1A
// - 0x15 bits 7 and 5 select gain 4; 0x16 bit 2 selects 20 mA
// - impedance equals code times 2.371 mV over gain times current
`timescale 1ns/1ps
`include "sald_map.svh"
module sald_core (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_nrst,
    // i2c pins
    input  wire logic             i_scl,
    input  wire logic             i_sda,
    output logic                  o_sda_out,
    output logic                  o_sda_oe,
    // analog front end
    input  wire sald_pkg::sald_ana_t i_ana,
    input  wire logic [7:0]       i_mag_code,
    output logic                  o_stim,
    output logic                  o_loopback,
    output logic                  o_gain4,
    output logic                  o_cur20,
    // dc diagnostic and channel control
    input  wire sald_pkg::sald_dc_t  i_dc,
    input  wire logic [7:0]       i_chan_state,
    input  wire logic             i_lo_done,
    input  wire logic             i_lo_present,
    output logic [3:0]            o_lo_req,
    output logic [7:0]            o_bridge_cfg
);
    sald_pkg::sald_ana_t  ana;
    sald_pkg::sald_i2c_st_t ist_ff;
    sald_pkg::sald_i2c_st_t ack_nxt_ff;
    sald_pkg::sald_ac_st_t  ast_ff;
    logic [1:0]  pins;
    logic        scl;
    logic        sda;
    logic        scl_q_ff;
    logic        sda_q_ff;
    logic [7:0]  sh_ff;
    logic [2:0]  cnt_ff;
    logic        rw_ff;
    logic        ackph_ff;
    logic        mack_ff;
    logic        oe_ff;
    logic [7:0]  ptr_ff;
    logic [7:0]  bridge_ff;
    logic [7:0]  en_gain_ff;
    logic [7:0]  lb_cur_ff;
    logic [7:0]  freq_ff;
    logic [7:0]  lo_ctrl_ff;
    logic [3:0]  lo_req_ff;
    logic [3:0]  lo_res_ff;
    logic        blocked_ff;
    logic [3:0]  en_q_ff;
    logic [1:0]  ch_ff;
    logic        lb_run_ff;
    logic [15:0] half_ff;
    logic [15:0] hcnt_ff;
    logic [15:0] pcnt_ff;
    logic [2:0]  per_ff;
    logic        stim_ff;
    logic        resp_q_ff;
    logic        got_ph_ff;
    logic [15:0] meas_ff;
    logic [15:0] phase_ff;
    logic [15:0] stim_cnt_ff;
    logic [15:0] ref_ff [2];
    logic [7:0]  imp_ff [4];
    logic [7:0]  rdata;
    logic [7:0]  chstate;

    sald_sync3 #(.W(2)) u_pin_sync (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        // inverted so the reset level matches the idle bus
        .i_async   (~{i_scl, i_sda}),
        .o_level   (pins)
    );

    sald_sync3 #(.W(4)) u_ana_sync (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_async   (i_ana),
        .o_level   (ana)
    );

    assign scl = ~pins[1];
    assign sda = ~pins[0];

    wire start    = scl & scl_q_ff & sda_q_ff & ~sda;
    wire stop     = scl & scl_q_ff & ~sda_q_ff & sda;
    wire scl_rise = scl & ~scl_q_ff;
    wire scl_fall = ~scl & scl_q_ff;
    wire [7:0] byte_in = {sh_ff[6:0], sda};
    wire byte_end = scl_rise & (cnt_ff == 3'h7);
    wire wr_stb   = (ist_ff == sald_pkg::SALD_I_WR) & byte_end;

    // i2c target: open drain, only ever pulls low
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ist_ff     <= sald_pkg::SALD_I_IDLE;
            ack_nxt_ff <= sald_pkg::SALD_I_IDLE;
            scl_q_ff   <= 1'b1;
            sda_q_ff   <= 1'b1;
            sh_ff      <= 8'h00;
            cnt_ff     <= 3'h0;
            rw_ff      <= 1'b0;
            ackph_ff   <= 1'b0;
            mack_ff    <= 1'b0;
            oe_ff      <= 1'b0;
            ptr_ff     <= 8'h00;
        end else begin
            scl_q_ff <= scl;
            sda_q_ff <= sda;
            if (scl_rise) begin
                sh_ff  <= byte_in;
                cnt_ff <= cnt_ff + 3'h1;
            end
            if (start) begin
                ist_ff <= sald_pkg::SALD_I_ADDR;
                cnt_ff <= 3'h0;
                oe_ff  <= 1'b0;
            end else if (stop) begin
                ist_ff <= sald_pkg::SALD_I_IDLE;
                oe_ff  <= 1'b0;
            end else begin
                unique case (ist_ff)
                    sald_pkg::SALD_I_IDLE: begin
                        oe_ff <= 1'b0;
                    end
                    sald_pkg::SALD_I_ADDR: begin
                        if (byte_end) begin
                            rw_ff      <= sda;
                            ackph_ff   <= 1'b0;
                            ack_nxt_ff <= sda ? sald_pkg::SALD_I_RD : sald_pkg::SALD_I_REG;
                            ist_ff     <= (sh_ff[6:0] == `SALD_I2C_ADDR) ?
                                          sald_pkg::SALD_I_ACK : sald_pkg::SALD_I_IDLE;
                        end
                    end
                    sald_pkg::SALD_I_ACK: begin
                        if (scl_fall && !ackph_ff) begin
                            oe_ff    <= 1'b1;
                            ackph_ff <= 1'b1;
                        end else if (scl_fall) begin
                            ist_ff <= ack_nxt_ff;
                            cnt_ff <= 3'h0;
                            sh_ff  <= rdata;
                            oe_ff  <= (ack_nxt_ff == sald_pkg::SALD_I_RD) ? ~rdata[7] : 1'b0;
                        end
                    end
                    sald_pkg::SALD_I_REG, sald_pkg::SALD_I_WR: begin
                        if (byte_end) begin
                            ptr_ff     <= (ist_ff == sald_pkg::SALD_I_REG) ? byte_in
                                                                            : ptr_ff + 8'h01;
                            ackph_ff   <= 1'b0;
                            ack_nxt_ff <= sald_pkg::SALD_I_WR;
                            ist_ff     <= sald_pkg::SALD_I_ACK;
                        end
                    end
                    sald_pkg::SALD_I_RD: begin
                        // already shifted on the rise
                        if (scl_fall) begin
                            oe_ff <= ~sh_ff[7];
                        end
                        if (byte_end) begin
                            ackph_ff <= 1'b0;
                            ist_ff   <= sald_pkg::SALD_I_RACK;
                        end
                    end
                    sald_pkg::SALD_I_RACK: begin
                        if (scl_fall && !ackph_ff) begin
                            oe_ff    <= 1'b0;
                            ackph_ff <= 1'b1;
                        end else if (scl_rise) begin
                            mack_ff <= ~sda;
                            if (!sda) begin
                                ptr_ff <= ptr_ff + 8'h01;
                            end
                        end else if (scl_fall) begin
                            cnt_ff <= 3'h0;
                            sh_ff  <= rdata;
                            oe_ff  <= mack_ff & ~rdata[7];
                            ist_ff <= mack_ff ? sald_pkg::SALD_I_RD : sald_pkg::SALD_I_IDLE;
                        end
                    end
                    default: begin
                        ist_ff <= sald_pkg::SALD_I_IDLE;
                    end
                endcase
            end
        end
    end

    // host register writes
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bridge_ff  <= `SALD_RST_BRIDGE;
            en_gain_ff <= `SALD_RST_EN_GAIN;
            lb_cur_ff  <= `SALD_RST_LB_CUR;
            freq_ff    <= `SALD_RST_FREQ;
            lo_ctrl_ff <= `SALD_RST_LO_CTRL;
        end else if (wr_stb) begin
            if (ptr_ff == `SALD_REG_BRIDGE)  bridge_ff  <= byte_in;
            if (ptr_ff == `SALD_REG_EN_GAIN) en_gain_ff <= byte_in;
            if (ptr_ff == `SALD_REG_LB_CUR)  lb_cur_ff  <= byte_in;
            if (ptr_ff == `SALD_REG_FREQ)    freq_ff    <= byte_in;
            if (ptr_ff == `SALD_REG_LO_CTRL) lo_ctrl_ff <= byte_in;
        end
    end

    wire [3:0] en_rise   = en_gain_ff[3:0] & ~en_q_ff;
    wire       one_hot   = (en_rise != 4'h0) && ((en_rise & (en_rise - 4'h1)) == 4'h0);
    wire [1:0] rise_idx  = en_rise[3] ? 2'd3 : en_rise[2] ? 2'd2 : en_rise[1] ? 2'd1 : 2'd0;
    wire       ac_start  = (ast_ff == sald_pkg::SALD_AC_IDLE) & one_hot & ~blocked_ff;
    wire       fault     = ana.uv | ana.ov | ana.ot;
    wire       half_end  = (hcnt_ff == half_ff - 16'h0001);
    wire       last_edge = half_end & stim_ff & (per_ff == 3'(`SALD_AC_PERIODS - 1));
    wire       resp_rise = ana.resp & ~resp_q_ff;
    // channels 1,2 share pair a; 3,4 share pair b
    wire       pair_b    = ~ch_ff[1];
    wire [15:0] half_sel = 16'(`SALD_HALF_BASE) >> freq_ff[1:0];

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ast_ff      <= sald_pkg::SALD_AC_IDLE;
            en_q_ff     <= 4'h0;
            ch_ff       <= 2'd0;
            lb_run_ff   <= 1'b0;
            half_ff     <= 16'h0001;
            hcnt_ff     <= 16'h0000;
            pcnt_ff     <= 16'h0000;
            per_ff      <= 3'h0;
            stim_ff     <= 1'b0;
            resp_q_ff   <= 1'b0;
            got_ph_ff   <= 1'b0;
            meas_ff     <= 16'h0000;
            phase_ff    <= 16'h0000;
            stim_cnt_ff <= 16'h0000;
            ref_ff      <= '{default: 16'h0000};
            imp_ff      <= '{default: 8'h00};
        end else begin
            en_q_ff   <= en_gain_ff[3:0];
            resp_q_ff <= ana.resp;
            unique case (ast_ff)
                sald_pkg::SALD_AC_IDLE: begin
                    if (ac_start) begin
                        ch_ff     <= rise_idx;
                        lb_run_ff <= lb_cur_ff[`SALD_BIT_LOOPBACK];
                        half_ff   <= half_sel;
                        hcnt_ff   <= 16'h0000;
                        pcnt_ff   <= 16'h0000;
                        per_ff    <= 3'h0;
                        stim_ff   <= 1'b1;
                        got_ph_ff <= 1'b0;
                        ast_ff    <= sald_pkg::SALD_AC_RUN;
                    end
                end
                sald_pkg::SALD_AC_RUN: begin
                    hcnt_ff <= half_end ? 16'h0000 : hcnt_ff + 16'h0001;
                    pcnt_ff <= (half_end & ~stim_ff) ? 16'h0000 : pcnt_ff + 16'h0001;
                    if (half_end) begin
                        stim_ff <= ~stim_ff;
                        if (!stim_ff) begin
                            per_ff    <= per_ff + 3'h1;
                            got_ph_ff <= 1'b0;
                        end
                    end
                    if (resp_rise && !got_ph_ff) begin
                        meas_ff   <= pcnt_ff;
                        got_ph_ff <= 1'b1;
                    end
                    if (fault) begin
                        stim_ff <= 1'b0;
                        ast_ff  <= sald_pkg::SALD_AC_DONE;
                    end else if (last_edge) begin
                        stim_ff <= 1'b0;
                        ast_ff  <= sald_pkg::SALD_AC_DONE;
                        // stored on entry to high impedance
                        phase_ff    <= meas_ff;
                        stim_cnt_ff <= {half_ff[14:0], 1'b0};
                        if (lb_run_ff) begin
                            ref_ff[pair_b] <= meas_ff;
                        end else begin
                            imp_ff[ch_ff] <= i_mag_code;
                        end
                    end
                end
                sald_pkg::SALD_AC_DONE: begin
                    if (!en_gain_ff[ch_ff]) begin
                        ast_ff <= sald_pkg::SALD_AC_IDLE;
                    end
                end
                default: begin
                    ast_ff <= sald_pkg::SALD_AC_IDLE;
                end
            endcase
        end
    end

    // abort lock and line-output check; a set of the lock or request beats a same-cycle clear
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blocked_ff <= 1'b0;
            lo_req_ff  <= 4'h0;
            lo_res_ff  <= 4'h0;
        end else begin
            if ((ast_ff == sald_pkg::SALD_AC_RUN) && fault) begin
                blocked_ff <= 1'b1;
            end else if (i_dc.done) begin
                blocked_ff <= 1'b0;
            end
            if (i_dc.done && lo_ctrl_ff[`SALD_BIT_LO_EN]) begin
                lo_req_ff <= i_dc.open_load;
                lo_res_ff <= lo_res_ff & ~i_dc.open_load;
            end else if (i_lo_done) begin
                lo_res_ff <= lo_res_ff | (lo_req_ff & {4{i_lo_present}});
                lo_req_ff <= 4'h0;
            end
        end
    end

    // tested channel shows diag, then high impedance
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_cs
            wire mine = (ast_ff != sald_pkg::SALD_AC_IDLE) && (ch_ff == 2'(g));
            assign chstate[2*g+1:2*g] = !mine ? i_chan_state[2*g+1:2*g] :
                (ast_ff == sald_pkg::SALD_AC_RUN) ? `SALD_CS_DIAG : `SALD_CS_HIZ;
        end
    endgenerate

    // read selection, unmapped offsets read zero
    always_comb begin
        unique case (ptr_ff)
            `SALD_REG_BRIDGE:   rdata = bridge_ff;
            `SALD_REG_CHSTATE:  rdata = chstate;
            `SALD_REG_EN_GAIN:  rdata = en_gain_ff;
            `SALD_REG_LB_CUR:   rdata = lb_cur_ff;
            `SALD_REG_IMP_CH1:  rdata = imp_ff[3];
            `SALD_REG_IMP_CH2:  rdata = imp_ff[2];
            `SALD_REG_IMP_CH3:  rdata = imp_ff[1];
            `SALD_REG_IMP_CH4:  rdata = imp_ff[0];
            `SALD_REG_PHASE_HI: rdata = phase_ff[15:8];
            `SALD_REG_PHASE_LO: rdata = phase_ff[7:0];
            `SALD_REG_STIM_HI:  rdata = stim_cnt_ff[15:8];
            `SALD_REG_STIM_LO:  rdata = stim_cnt_ff[7:0];
            `SALD_REG_FREQ:     rdata = freq_ff;
            `SALD_REG_LO_CTRL:  rdata = lo_ctrl_ff;
            `SALD_REG_LO_STAT:  rdata = {blocked_ff, 3'h0, lo_res_ff};
            `SALD_REG_REFA_HI:  rdata = ref_ff[0][15:8];
            `SALD_REG_REFA_LO:  rdata = ref_ff[0][7:0];
            `SALD_REG_REFB_HI:  rdata = ref_ff[1][15:8];
            `SALD_REG_REFB_LO:  rdata = ref_ff[1][7:0];
            default:            rdata = 8'h00;
        endcase
    end

    assign o_sda_out    = 1'b0;
    assign o_sda_oe     = oe_ff;
    assign o_stim       = stim_ff;
    assign o_loopback   = lb_run_ff;
    assign o_gain4      = en_gain_ff[`SALD_BIT_GAIN_A] & en_gain_ff[`SALD_BIT_GAIN_B];
    assign o_cur20      = lb_cur_ff[`SALD_BIT_CUR20];
    assign o_lo_req     = lo_req_ff;
    assign o_bridge_cfg = bridge_ff;
endmodule

// ==== rtl/sald_map.svh ====
`ifndef SALD_MAP_SVH
`define SALD_MAP_SVH

// register offsets
`define SALD_REG_BRIDGE      8'h00
`define SALD_REG_CHSTATE     8'h0F
`define SALD_REG_EN_GAIN     8'h15
`define SALD_REG_LB_CUR      8'h16
`define SALD_REG_IMP_CH1     8'h17
`define SALD_REG_IMP_CH2     8'h18
`define SALD_REG_IMP_CH3     8'h19
`define SALD_REG_IMP_CH4     8'h1A
`define SALD_REG_PHASE_HI    8'h1B
`define SALD_REG_PHASE_LO    8'h1C
`define SALD_REG_STIM_HI     8'h1D
`define SALD_REG_STIM_LO     8'h1E
`define SALD_REG_FREQ        8'h2A
`define SALD_REG_LO_CTRL     8'h30
`define SALD_REG_LO_STAT     8'h31
`define SALD_REG_REFA_HI     8'h32
`define SALD_REG_REFA_LO     8'h33
`define SALD_REG_REFB_HI     8'h34
`define SALD_REG_REFB_LO     8'h35

// field positions
`define SALD_BIT_LOOPBACK    7
`define SALD_BIT_CUR20       2
`define SALD_BIT_GAIN_A      7
`define SALD_BIT_GAIN_B      5
`define SALD_BIT_LO_EN       0
`define SALD_BIT_BLOCKED     7

// reset values
`define SALD_RST_BRIDGE      8'h00
`define SALD_RST_EN_GAIN     8'h00
`define SALD_RST_LB_CUR      8'h00
`define SALD_RST_FREQ        8'h00
`define SALD_RST_LO_CTRL     8'h00

// channel state codes, two bits per channel, channel 1 in bits 7:6
`define SALD_CS_HIZ          2'h1
`define SALD_CS_DIAG         2'h3

// timing
`define SALD_CLK_HZ          250000000
`define SALD_F_BASE_HZ       18750
`define SALD_HALF_BASE       (`SALD_CLK_HZ / `SALD_F_BASE_HZ / 2)
`define SALD_AC_PERIODS      8
`define SALD_RETEST_MS       200
`define SALD_I2C_ADDR        7'h2C

`endif

// ==== rtl/sald_pkg.sv ====
package sald_pkg;

    typedef enum logic [2:0] {
        SALD_I_IDLE,
        SALD_I_ADDR,
        SALD_I_ACK,
        SALD_I_REG,
        SALD_I_WR,
        SALD_I_RD,
        SALD_I_RACK
    } sald_i2c_st_t;

    typedef enum logic [1:0] {
        SALD_AC_IDLE,
        SALD_AC_RUN,
        SALD_AC_DONE
    } sald_ac_st_t;

    typedef struct packed {
        logic uv;
        logic ov;
        logic ot;
        logic resp;
    } sald_ana_t;

    typedef struct packed {
        logic [3:0] open_load;
        logic       done;
    } sald_dc_t;

endpackage

// ==== rtl/sald_sync3.sv ====
`timescale 1ns/1ps
module sald_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    // async in, filtered out
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] lvl_ff;

    // a change counts only once stages two and three agree
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            lvl_ff <= '0;
        end else begin
            s1_ff  <= i_async;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
        end
    end

    assign o_level = lvl_ff;
endmodule
